/* pkg/iocs_pkg.sv */
// package for the i/o chip select decoder: widths, modes and carriers
package iocs_pkg;

  localparam int ADDR_W = 24;
  localparam int IO_W = 16;
  localparam int NUM_CS = 8;
  localparam int LIN_W = 15;
  localparam logic [7:0] WINDOW_PAGE = 8'hfe;
  localparam logic [7:0] BASIC_LIMIT = 8'hff;
  localparam int GRP_LO = 1;
  localparam int GRP_HI = 3;
  localparam int PAGE_LO = 4;
  localparam int PAGE_HI = 15;
  localparam logic [11:0] PAGE_RST = 12'h000;
  localparam logic [NUM_CS-1:0] CS_IDLE = 8'h00;
  localparam logic [LIN_W-1:0] LIN_IDLE = 15'h0000;

  typedef enum logic [1:0]
  {
    IOCS_SPLIT,
    IOCS_BYTE_ONLY,
    IOCS_SINGLE,
    IOCS_LINEAR
  } iocs_mode_e;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic upper_byte_enable_n;
    logic mem_n_io;
    logic read_n;
    logic write_n;
  } iocs_bus_s;

  typedef struct packed
  {
    logic io_read_command_n;
    logic io_write_command_n;
    logic memory_read_command_n;
    logic memory_write_command_n;
  } iocs_cmd_s;

endpackage : iocs_pkg

/* hw/iocs_decoder.sv */
// i/o chip select decoder with memory window alias and byte lane selects
// What this block does
// (RL1) the memory window fe0000h to feffffh is treated as the i/o space.
// (RL2) window accesses decode chip selects from the low sixteen bits.
// (RL3) window accesses issue i/o read and write commands, not memory ones.
// (RL4) an option lets each group device answer both i/o and window addresses; linear selects answer i/o only.
// (RL5) upper lane byte devices take odd addresses, lower lane even ones.
// (RL6) the lowest bit is no register select; higher bits go out instead.
// (RL7) lowest bit and upper byte enable qualify selects of paired devices.
// (RL8) split mode: an even word transfer also selects the odd neighbour.
// (RL9) byte only mode: selects assert only for byte transfers.
// (RL10) single mode: odd selects on bytes, even selects on bytes and words.
// (RL11) a second stage compares the high bits beyond the first 16 bytes.
// (RL12) decoded selects are captured on the address latch strobe.
// (RL13) a converter muxes the 16-bit bus onto an 8-bit bus.
// (RL14) word devices sit at even addresses and are selected only for words.
// (RL15) linear mode drives one select per latched bit a1 to a15.
// (RL16) selects drop outside assigned ranges and for foreign cycles.
`timescale 1ns/100ps

module iocs_decoder
(
  sys_clk,
  arst_n,
  addr_latch_strobe,
  bus_in,
  mode,
  dual_map_en,
  io_page,
  data_in,
  byte_data_in,
  odd_cs_n,
  even_cs_n,
  word_cs_n,
  linear_cs,
  reg_sel_addr,
  cmd_out,
  data_out,
  byte_data_out,
  byte_lane_odd
);

  input wire logic sys_clk;
  input wire logic arst_n;
  input wire logic addr_latch_strobe;
  input wire iocs_pkg::iocs_bus_s bus_in;
  input wire iocs_pkg::iocs_mode_e mode;
  input wire logic dual_map_en;
  input wire logic [11:0] io_page;
  input wire logic [15:0] data_in;
  input wire logic [7:0] byte_data_in;
  output logic [iocs_pkg::NUM_CS-1:0] odd_cs_n;
  output logic [iocs_pkg::NUM_CS-1:0] even_cs_n;
  output logic [iocs_pkg::NUM_CS-1:0] word_cs_n;
  output logic [iocs_pkg::LIN_W-1:0] linear_cs;
  output logic [2:0] reg_sel_addr;
  output iocs_pkg::iocs_cmd_s cmd_out;
  output logic [15:0] data_out;
  output logic [7:0] byte_data_out;
  output logic byte_lane_odd;

  ////////////////////////////////////////////////////////////////////////////
  // decode functions

  function automatic logic [iocs_pkg::NUM_CS-1:0] one_hot
  (
    input logic [2:0] grp
  );
    logic [iocs_pkg::NUM_CS-1:0] v;
    v = '0;
    v[grp] = 1'b1;
    return v;
  endfunction : one_hot

  function automatic logic in_window
  (
    input logic [iocs_pkg::ADDR_W-1:0] a
  );
    return a[23:16] == iocs_pkg::WINDOW_PAGE;
  endfunction : in_window

  ////////////////////////////////////////////////////////////////////////////
  // cycle classification

  wire logic [iocs_pkg::IO_W-1:0] io_addr;
  wire logic win_hit;
  wire logic io_cycle;
  wire logic mem_cycle;
  wire logic win_cycle;
  wire logic dev_cycle;
  wire logic low_bit;
  wire logic ube_n;
  wire logic byte_even;
  wire logic byte_odd;
  wire logic word_even;
  wire logic page_hit;
  wire logic [2:0] grp;
  wire logic [iocs_pkg::NUM_CS-1:0] grp_sel;

  assign io_addr = bus_in.addr[iocs_pkg::IO_W-1:0]; // see RL2
  assign win_hit = in_window(bus_in.addr); // see RL1
  assign io_cycle = !bus_in.mem_n_io;
  assign mem_cycle = bus_in.mem_n_io;
  assign win_cycle = mem_cycle && win_hit;
  // the window always answers; dual map adds the plain i/o space
  assign dev_cycle = win_cycle || (io_cycle && dual_map_en); // see RL4
  assign low_bit = io_addr[0];
  assign ube_n = bus_in.upper_byte_enable_n;
  assign byte_even = !low_bit && ube_n; // see RL5
  assign byte_odd = low_bit && !ube_n; // see RL5
  assign word_even = !low_bit && !ube_n; // see RL14
  assign page_hit = io_addr[iocs_pkg::PAGE_HI:iocs_pkg::PAGE_LO] ==
                    io_page; // see RL11
  assign grp = io_addr[iocs_pkg::GRP_HI:iocs_pkg::GRP_LO]; // see RL6
  assign grp_sel = (dev_cycle && page_hit) ? one_hot(grp) :
                   iocs_pkg::CS_IDLE; // see RL16

  ////////////////////////////////////////////////////////////////////////////
  // per mode lane qualification

  logic odd_q;
  logic even_q;
  logic word_q;

  always_comb
  begin
    odd_q = 1'b0;
    even_q = 1'b0;
    word_q = 1'b0;
    case (mode)
      iocs_pkg::IOCS_SPLIT:
      begin
        odd_q = byte_odd || word_even; // see RL8
        even_q = byte_even || word_even; // see RL8
        word_q = word_even; // see RL14
      end
      iocs_pkg::IOCS_BYTE_ONLY:
      begin
        odd_q = byte_odd; // see RL9
        even_q = byte_even; // see RL9
        word_q = 1'b0;
      end
      iocs_pkg::IOCS_SINGLE:
      begin
        odd_q = byte_odd; // see RL10
        even_q = byte_even || word_even; // see RL10
        word_q = word_even;
      end
      iocs_pkg::IOCS_LINEAR:
      begin
        odd_q = 1'b0;
        even_q = 1'b0;
        word_q = 1'b0;
      end
      default:
      begin
        odd_q = 1'b0;
        even_q = 1'b0;
        word_q = 1'b0;
      end
    endcase
  end

  wire logic [iocs_pkg::NUM_CS-1:0] odd_next;
  wire logic [iocs_pkg::NUM_CS-1:0] even_next;
  wire logic [iocs_pkg::NUM_CS-1:0] word_next;
  wire logic [iocs_pkg::LIN_W-1:0] lin_next;
  wire logic lin_ok;

  // the per mode lane qualifiers gate every group select
  genvar g;

  generate
    for (g = 0; g < iocs_pkg::NUM_CS; g = g + 1)
    begin : g_lane
      assign odd_next[g] = odd_q && grp_sel[g]; // see RL7
      assign even_next[g] = even_q && grp_sel[g]; // see RL7
      assign word_next[g] = word_q && grp_sel[g]; // see RL14
    end
  endgenerate

  assign lin_ok = mode == iocs_pkg::IOCS_LINEAR && io_cycle;
  assign lin_next = lin_ok ? io_addr[15:1] : iocs_pkg::LIN_IDLE; // see RL15

  ////////////////////////////////////////////////////////////////////////////
  // command steering

  iocs_pkg::iocs_cmd_s cmd_next;

  always_comb
  begin
    cmd_next.io_read_command_n = !((io_cycle || win_cycle) &&
                                   !bus_in.read_n); // see RL3
    cmd_next.io_write_command_n = !((io_cycle || win_cycle) &&
                                    !bus_in.write_n); // see RL3
    cmd_next.memory_read_command_n = !(mem_cycle && !win_hit &&
                                       !bus_in.read_n); // see RL3
    cmd_next.memory_write_command_n = !(mem_cycle && !win_hit &&
                                        !bus_in.write_n); // see RL3
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16 to 8 bit converter

  wire logic [7:0] byte_next;
  wire logic [15:0] wide_next;

  assign byte_next = low_bit ? data_in[15:8] : data_in[7:0]; // see RL13
  assign wide_next = {byte_data_in, byte_data_in}; // see RL13

  ////////////////////////////////////////////////////////////////////////////
  // select latches strobed by the address latch strobe

  logic [iocs_pkg::NUM_CS-1:0] odd_reg;
  logic [iocs_pkg::NUM_CS-1:0] even_reg;
  logic [iocs_pkg::NUM_CS-1:0] word_reg;
  logic [iocs_pkg::LIN_W-1:0] lin_reg;
  logic [2:0] rsel_reg;
  logic lane_reg;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      odd_reg <= iocs_pkg::CS_IDLE;
      even_reg <= iocs_pkg::CS_IDLE;
      word_reg <= iocs_pkg::CS_IDLE;
      lin_reg <= iocs_pkg::LIN_IDLE;
    end
    else if (addr_latch_strobe)
    begin
      odd_reg <= odd_next; // see RL12
      even_reg <= even_next; // see RL12
      word_reg <= word_next; // see RL12
      lin_reg <= lin_next; // see RL15
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsel_reg <= 3'h0;
      lane_reg <= 1'b0;
    end
    else if (addr_latch_strobe)
    begin
      rsel_reg <= io_addr[3:1]; // see RL6
      lane_reg <= low_bit; // see RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output flops

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      odd_cs_n <= '1;
      even_cs_n <= '1;
      word_cs_n <= '1;
      linear_cs <= iocs_pkg::LIN_IDLE;
    end
    else
    begin
      odd_cs_n <= ~odd_reg;
      even_cs_n <= ~even_reg;
      word_cs_n <= ~word_reg;
      linear_cs <= lin_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_sel_addr <= 3'h0;
      byte_lane_odd <= 1'b0;
    end
    else
    begin
      reg_sel_addr <= rsel_reg;
      byte_lane_odd <= lane_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_out <= '1;
      data_out <= 16'h0000;
      byte_data_out <= 8'h00;
    end
    else
    begin
      cmd_out <= cmd_next;
      data_out <= wide_next;
      byte_data_out <= byte_next;
    end
  end

endmodule : iocs_decoder

/* tb/iocs_decoder_properties.sv */
// port checker for the i/o chip select decoder
`timescale 1ns/100ps
module iocs_decoder_props
(
  sys_clk,
  arst_n,
  addr_latch_strobe,
  bus_in,
  mode,
  dual_map_en,
  io_page,
  odd_cs_n,
  even_cs_n,
  word_cs_n,
  linear_cs,
  cmd_out
);
  input wire logic sys_clk;
  input wire logic arst_n;
  input wire logic addr_latch_strobe;
  input wire iocs_pkg::iocs_bus_s bus_in;
  input wire iocs_pkg::iocs_mode_e mode;
  input wire logic dual_map_en;
  input wire logic [11:0] io_page;
  input wire logic [7:0] odd_cs_n;
  input wire logic [7:0] even_cs_n;
  input wire logic [7:0] word_cs_n;
  input wire logic [14:0] linear_cs;
  input wire iocs_pkg::iocs_cmd_s cmd_out;
  wire [23:0] a = bus_in.addr;
  wire [14:0] la = a[15:1];
  wire [7:0] oh = 8'h01 << a[3:1];
  wire [7:0] all_n = odd_cs_n & even_cs_n & word_cs_n;
  wire [3:0] c = cmd_out;
  wire [1:0] m = mode;
  wire win = bus_in.mem_n_io && a[23:16] == 8'hfe;
  wire ioc = win || !bus_in.mem_n_io;
  wire dev = win || (dual_map_en && !bus_in.mem_n_io);
  wire go = addr_latch_strobe && dev && a[15:4] == io_page;
  wire wd = !a[0] && !bus_in.upper_byte_enable_n;
  wire ob = a[0] && !bus_in.upper_byte_enable_n;
  wire rd = !bus_in.read_n;
  wire wr = !bus_in.write_n;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////
  property p_io_rd; ioc && rd && !wr |=> c == 4'h7; endproperty
  a_io_rd: assert property (p_io_rd) else $error("io read cmd");
  property p_io_wr; ioc && wr && !rd |=> c == 4'hb; endproperty
  a_io_wr: assert property (p_io_wr) else $error("io write cmd");
  property p_split;
    go && m == 2'h0 && wd |-> ##2 odd_cs_n == ~$past(oh, 2)
      && even_cs_n == ~$past(oh, 2) && word_cs_n == ~$past(oh, 2);
  endproperty
  a_split: assert property (p_split) else $error("split word");
  property p_byte; go && m == 2'h1 && wd |-> ##2 all_n == 8'hff; endproperty
  a_byte: assert property (p_byte) else $error("byte only word");
  property p_single;
    go && m == 2'h2 && wd |-> ##2 odd_cs_n == 8'hff
      && even_cs_n == ~$past(oh, 2);
  endproperty
  a_single: assert property (p_single) else $error("single word");
  property p_lane;
    go && m != 2'h3 && ob |-> ##2 even_cs_n == 8'hff
      && odd_cs_n == ~$past(oh, 2);
  endproperty
  a_lane: assert property (p_lane) else $error("odd lane");
  property p_none;
    addr_latch_strobe && !go && m != 2'h3 |-> ##2 all_n == 8'hff;
  endproperty
  a_none: assert property (p_none) else $error("stray select");
  property p_lin;
    addr_latch_strobe && m == 2'h3 && !bus_in.mem_n_io && dual_map_en
      |-> ##2 linear_cs == $past(la, 2);
  endproperty
  a_lin: assert property (p_lin) else $error("linear select");
  c_split: cover property (go && m == 2'h0 && wd);
  c_win: cover property (win && rd);
  c_lin: cover property (addr_latch_strobe && m == 2'h3);
endmodule : iocs_decoder_props
bind iocs_decoder iocs_decoder_props i_props
(
  .sys_clk, .arst_n, .addr_latch_strobe, .bus_in, .mode, .dual_map_en,
  .io_page, .odd_cs_n, .even_cs_n, .word_cs_n, .linear_cs, .cmd_out
);

/* tb/iocs_bus_model.sv */
// local bus controller model running one bus cycle at a time
`timescale 1ns/100ps
module iocs_bus_model
(
  sys_clk,
  bus_in,
  addr_latch_strobe
);
  input wire logic sys_clk;
  output iocs_pkg::iocs_bus_s bus_in;
  output logic addr_latch_strobe;
  initial
  begin
    bus_in = {24'h000000, 4'hb};
    addr_latch_strobe = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // f is upper byte enable, memory flag, read and write levels
  task cycle(input logic [23:0] a, input logic [3:0] f);
    @(posedge sys_clk);
    bus_in <= {a, f[3:2], 2'h3};
    addr_latch_strobe <= 1'b1;
    @(posedge sys_clk);
    addr_latch_strobe <= 1'b0;
    bus_in.read_n <= f[1];
    bus_in.write_n <= f[0];
    repeat (2) @(posedge sys_clk);
  endtask : cycle
  // released address lines churn rather than hold
  task idle();
    @(posedge sys_clk);
    bus_in <= {~bus_in.addr, 4'hb};
  endtask : idle
endmodule : iocs_bus_model

/* tb/test_iocs_decoder.sv */
// self-checking bench for the i/o chip select decoder
`timescale 1ns/100ps
module test_iocs_decoder;
  logic sys_clk;
  logic arst_n;
  logic addr_latch_strobe;
  iocs_pkg::iocs_bus_s bus_in;
  iocs_pkg::iocs_mode_e mode;
  logic dual_map_en;
  logic [11:0] io_page;
  logic [15:0] data_in;
  logic [7:0] byte_data_in;
  logic [7:0] odd_cs_n;
  logic [7:0] even_cs_n;
  logic [7:0] word_cs_n;
  logic [14:0] linear_cs;
  logic [2:0] reg_sel_addr;
  iocs_pkg::iocs_cmd_s cmd_out;
  logic [15:0] data_out;
  logic [7:0] byte_data_out;
  logic byte_lane_odd;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  iocs_bus_model i_bus (.sys_clk, .bus_in, .addr_latch_strobe);
  iocs_decoder i_dut
  (
    .sys_clk, .arst_n, .addr_latch_strobe, .bus_in, .mode, .dual_map_en,
    .io_page, .data_in, .byte_data_in, .odd_cs_n, .even_cs_n, .word_cs_n,
    .linear_cs, .reg_sel_addr, .cmd_out, .data_out, .byte_data_out,
    .byte_lane_odd
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task run(input logic [23:0] a, input logic [3:0] f,
    input logic [23:0] cs, input logic [3:0] c);
    i_bus.cycle(a, f);
    #1;
    check({odd_cs_n, even_cs_n, word_cs_n}, cs);
    check(cmd_out, c);
    check(reg_sel_addr, a[3:1]);
    check(byte_lane_odd, a[0]);
    check(byte_data_out, a[0] ? data_in[15:8] : data_in[7:0]);
    check(data_out, {byte_data_in, byte_data_in});
    i_bus.idle();
  endtask : run
  task s_split();
    run(24'h000002, 4'h1, 24'hfdfdfd, 4'h7);
    run(24'h000003, 4'h2, 24'hfdffff, 4'hb);
    run(24'h000004, 4'h9, 24'hfffbff, 4'h7);
    check(linear_cs, 15'h0000);
  endtask : s_split
  task s_window();
    run(24'hfe0006, 4'hd, 24'hfff7ff, 4'h7);
    run(24'hfe0007, 4'h6, 24'hf7ffff, 4'hb);
    run(24'hfd0006, 4'hd, 24'hffffff, 4'hd);
  endtask : s_window
  task s_byte_only();
    mode <= iocs_pkg::IOCS_BYTE_ONLY;
    run(24'h000002, 4'h1, 24'hffffff, 4'h7);
    run(24'h000002, 4'h9, 24'hfffdff, 4'h7);
  endtask : s_byte_only
  task s_single();
    mode <= iocs_pkg::IOCS_SINGLE;
    run(24'h00000a, 4'h1, 24'hffdfdf, 4'h7);
    run(24'h00000b, 4'h2, 24'hdfffff, 4'hb);
  endtask : s_single
  task s_page();
    io_page <= 12'h001;
    run(24'h000012, 4'h9, 24'hfffdff, 4'h7);
    run(24'h000002, 4'h9, 24'hffffff, 4'h7);
    io_page <= 12'h000;
  endtask : s_page
  task s_dual();
    dual_map_en <= 1'b0;
    run(24'h000002, 4'h9, 24'hffffff, 4'h7);
    run(24'hfe0002, 4'hd, 24'hfffdff, 4'h7);
    dual_map_en <= 1'b1;
  endtask : s_dual
  task s_linear();
    mode <= iocs_pkg::IOCS_LINEAR;
    dual_map_en <= 1'b1;
    i_bus.cycle(24'h004a03, 4'h9);
    #1;
    check(linear_cs, 15'h2501);
    i_bus.idle();
  endtask : s_linear
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    mode = iocs_pkg::IOCS_SPLIT;
    dual_map_en = 1'b1;
    io_page = 12'h000;
    data_in = 16'hab12;
    byte_data_in = 8'h5c;
    repeat (2) @(posedge sys_clk);
    check({odd_cs_n, even_cs_n, word_cs_n, cmd_out}, 28'hfffffff);
    arst_n <= 1'b1;
    s_split();
    s_window();
    s_byte_only();
    s_single();
    s_page();
    s_dual();
    s_linear();
    close_out();
  end
endmodule : test_iocs_decoder
